// ### core/nand_strobe_pkg.sv
// How it works
// - every strobe phase is a whole number of flash half periods, except read data setup.
// - latch enables and chip select stand one period around the latching strobe edge.
// - successive write strobe falling edges are at least two periods apart.
// - the write strobe stays high at least one period between pulses.
// - read strobe falls no sooner than four periods after the flash reports ready.
// - each read strobe low pulse is at least one and a half periods wide.
// - successive read strobe falling edges are at least two periods apart.
// - read strobe stays high at least half a period between pulses.
// - read data is captured on the internal flash clock, not an external strobe.
// - the divider setting is clamped so the flash clock never exceeds 66 MHz.
// - out of reset the divider is set for the 16.63 MHz default; half periods rounded up give a 15.625 MHz flash clock.
// - divide by twelve or eight of the cpu clock is recommended.
package nand_strobe_pkg;

	// ---------------------------------------------------------------
	// clock rates
	// ---------------------------------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int CPU_KHZ = 266000;
	localparam int FLASH_MAX_KHZ = 66000;
	localparam int FLASH_DEFAULT_KHZ = 16630;
	localparam int DIV_W = 5;
	localparam int HALF_W = 8;
	// smallest divider that keeps the flash clock at or under its limit
	localparam int MIN_DIV_I = (CPU_KHZ + FLASH_MAX_KHZ - 1) / FLASH_MAX_KHZ;
	localparam int DEFAULT_DIV_I =
		(CPU_KHZ + FLASH_DEFAULT_KHZ / 2) / FLASH_DEFAULT_KHZ;
	localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'(MIN_DIV_I);
	localparam logic [DIV_W-1:0] DEFAULT_DIV = DIV_W'(DEFAULT_DIV_I);
	localparam logic [DIV_W-1:0] DIV_SLOW = 5'h0C;
	localparam logic [DIV_W-1:0] DIV_FAST = 5'h08;

	// ---------------------------------------------------------------
	// phase lengths in flash half periods
	// ---------------------------------------------------------------
	localparam logic [HALF_W-1:0] WR_SETUP_H = 8'h02;
	localparam logic [HALF_W-1:0] WR_PULSE_H = 8'h02;
	localparam logic [HALF_W-1:0] WR_HOLD_H = 8'h02;
	localparam logic [HALF_W-1:0] RR_WAIT_H = 8'h08;
	localparam logic [HALF_W-1:0] RD_LOW_H = 8'h03;
	localparam logic [HALF_W-1:0] RD_HIGH_H = 8'h01;
	localparam logic [HALF_W-1:0] ONE_H = 8'h01;

	// ---------------------------------------------------------------
	// read data setup, an absolute time
	// ---------------------------------------------------------------
	localparam int DATA_SETUP_NS = 15;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS * CLK_KHZ + 999999) / 1000000;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_WRITE, OP_READ} op_e;

	// system cycles per flash half period, rounded up so no phase is short
	function automatic logic [HALF_W-1:0] half_count(
		input logic [DIV_W-1:0] div
	);
		int n;
		n = (int'(div) * CLK_KHZ + 2 * CPU_KHZ - 1) / (2 * CPU_KHZ);
		if (n < 1)
		begin
			n = 1;
		end
		return HALF_W'(n);
	endfunction

endpackage

// ### core/two_entry_buffer.sv
module two_entry_buffer
	import nand_strobe_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = mem_q[rd_ptr_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// storage needs no reset: out_valid guards it
	always_ff @(posedge clock)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

endmodule // two_entry_buffer

// ### core/nand_strobe_timing.sv
module nand_strobe_timing
	import nand_strobe_pkg::*;
#(
	parameter int DATA_W = 8
)(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic div_load,
	input wire logic [DIV_W-1:0] flash_clk_divider,
	input wire logic op_valid,
	output logic op_ready,
	input wire op_e op_kind,
	input wire logic [DATA_W-1:0] op_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [DATA_W-1:0] rd_data,
	output logic busy,
	output logic flash_clk,
	output logic cmd_latch_enable,
	output logic addr_latch_enable,
	output logic flash_chip_select_n,
	output logic flash_write_strobe_n,
	output logic flash_read_strobe_n,
	output logic [DATA_W-1:0] flash_data_out,
	output logic flash_data_oe,
	input wire logic [DATA_W-1:0] flash_data_in,
	input wire logic flash_ready
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (DATA_W != 8 && DATA_W != 16)
	begin : g_width_check
		$error("nand_strobe_timing: DATA_W must be 8 or 16");
	end
	// the input synchroniser doubles as the read data setup window
	if (DATA_SETUP_CYC > SYNC_STAGES)
	begin : g_setup_check
		$error("nand_strobe_timing: clock too fast for read data setup");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD,
		ST_WAIT_RDY,
		ST_RR_GAP,
		ST_RD_LOW,
		ST_RD_HIGH
	} state_e;

	// ---------------------------------------------------------------
	// flash clock divider
	// ---------------------------------------------------------------
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_clamped;
	logic [HALF_W-1:0] half_len;
	logic [HALF_W-1:0] sys_cnt_q;
	logic tick;
	logic flash_clk_q;

	// a setting that would overspeed the flash is raised to the limit
	assign div_clamped = (flash_clk_divider < MIN_DIV) ? MIN_DIV :
		flash_clk_divider;
	assign half_len = half_count(div_q);
	// tick marks each flash clock edge, rising and falling alike
	assign tick = (sys_cnt_q >= half_len - ONE_H);

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			div_q <= DEFAULT_DIV;
		else if (div_load)
			div_q <= div_clamped;
	end

	// a new divider takes effect at the next edge; current phase may stretch
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sys_cnt_q <= '0;
			flash_clk_q <= 1'b0;
		end
		else if (tick)
		begin
			sys_cnt_q <= '0;
			flash_clk_q <= ~flash_clk_q;
		end
		else
			sys_cnt_q <= sys_cnt_q + ONE_H;
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic rdy_s1_q;
	logic rdy_s2_q;
	logic [DATA_W-1:0] din_s1_q;
	logic [DATA_W-1:0] din_s2_q;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
			din_s1_q <= '0;
			din_s2_q <= '0;
		end
		else
		begin
			rdy_s1_q <= flash_ready;
			rdy_s2_q <= rdy_s1_q;
			din_s1_q <= flash_data_in;
			din_s2_q <= din_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// read data buffer
	// ---------------------------------------------------------------
	logic buf_in_ready;
	logic capture;

	two_entry_buffer #(
		.WIDTH(DATA_W)
	) u_rd_buf (
		.clock(clock),
		.reset_n(reset_n),
		.in_valid(capture),
		.in_ready(buf_in_ready),
		.in_data(din_s2_q),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// ---------------------------------------------------------------
	// strobe sequencer
	// ---------------------------------------------------------------
	state_e state_q;
	state_e state_d;
	logic [HALF_W-1:0] left_q;
	logic [HALF_W-1:0] left_d;
	op_e kind_q;
	logic last_read_q;
	logic [DATA_W-1:0] wdata_q;
	logic accept;
	logic phase_end;
	logic is_read;

	assign is_read = (op_kind == OP_READ);
	// a read is taken only with buffer room, so a stalled reader loses nothing
	assign op_ready = (state_q == ST_IDLE) && tick &&
		(!is_read || buf_in_ready);
	assign accept = op_valid && op_ready;
	assign phase_end = tick && (left_q == ONE_H);
	// sampled at the flash clock edge that ends the low pulse
	assign capture = phase_end && (state_q == ST_RD_LOW);
	assign busy = (state_q != ST_IDLE);

	always_comb
	begin
		state_d = state_q;
		left_d = left_q;
		if (tick && left_q != ONE_H)
			left_d = left_q - ONE_H;
		unique case (state_q)
			ST_IDLE:
			begin
				if (accept && !is_read)
				begin
					state_d = ST_SETUP;
					left_d = WR_SETUP_H;
				end
				else if (accept && last_read_q)
				begin
					state_d = ST_RD_LOW;
					left_d = RD_LOW_H;
				end
				else if (accept)
					state_d = ST_WAIT_RDY;
			end
			ST_SETUP:
			begin
				if (phase_end)
				begin
					state_d = ST_STROBE;
					left_d = WR_PULSE_H;
				end
			end
			ST_STROBE:
			begin
				if (phase_end)
				begin
					state_d = ST_HOLD;
					left_d = WR_HOLD_H;
				end
			end
			ST_HOLD:
			begin
				// setup plus pulse plus hold spans well over two periods
				if (phase_end)
					state_d = ST_IDLE;
			end
			ST_WAIT_RDY:
			begin
				if (tick && rdy_s2_q)
				begin
					state_d = ST_RR_GAP;
					left_d = RR_WAIT_H;
				end
			end
			ST_RR_GAP:
			begin
				if (phase_end)
				begin
					state_d = ST_RD_LOW;
					left_d = RD_LOW_H;
				end
			end
			ST_RD_LOW:
			begin
				if (phase_end)
				begin
					state_d = ST_RD_HIGH;
					left_d = RD_HIGH_H;
				end
			end
			ST_RD_HIGH:
			begin
				if (phase_end)
					state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_IDLE;
			left_q <= ONE_H;
		end
		else
		begin
			state_q <= state_d;
			left_q <= left_d;
		end
	end

	// back-to-back reads skip the ready wait; any other op restarts it
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			kind_q <= OP_CMD;
			last_read_q <= 1'b0;
			wdata_q <= '0;
		end
		else if (accept)
		begin
			kind_q <= op_kind;
			last_read_q <= is_read;
			wdata_q <= op_data;
		end
	end

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	logic in_write_d;
	logic in_op_d;
	op_e kind_d;
	logic cle_q;
	logic ale_q;
	logic ce_n_q;
	logic we_n_q;
	logic re_n_q;
	logic oe_q;
	logic [DATA_W-1:0] dout_q;

	assign kind_d = accept ? op_kind : kind_q;
	assign in_op_d = (state_d != ST_IDLE);
	assign in_write_d = (state_d == ST_SETUP) || (state_d == ST_STROBE) ||
		(state_d == ST_HOLD);

	// outputs follow the next state so every pin edge lands on a tick
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			ce_n_q <= 1'b1;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			oe_q <= 1'b0;
			dout_q <= '0;
		end
		else
		begin
			cle_q <= in_write_d && (kind_d == OP_CMD);
			ale_q <= in_write_d && (kind_d == OP_ADDR);
			ce_n_q <= !in_op_d;
			we_n_q <= (state_d != ST_STROBE);
			re_n_q <= (state_d != ST_RD_LOW);
			oe_q <= in_write_d;
			dout_q <= accept ? op_data : wdata_q;
		end
	end

	assign flash_clk = flash_clk_q;
	assign cmd_latch_enable = cle_q;
	assign addr_latch_enable = ale_q;
	assign flash_chip_select_n = ce_n_q;
	assign flash_write_strobe_n = we_n_q;
	assign flash_read_strobe_n = re_n_q;
	assign flash_data_out = dout_q;
	assign flash_data_oe = oe_q;

endmodule // nand_strobe_timing

// ### testbench/nand_strobe_chk.sv
module nand_strobe_chk
	import nand_strobe_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic cmd_latch_enable,
	input wire logic addr_latch_enable,
	input wire logic flash_data_oe,
	input wire logic flash_clk,
	input wire logic flash_chip_select_n,
	input wire logic flash_write_strobe_n,
	input wire logic flash_read_strobe_n,
	input wire logic flash_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// half periods since: ce edge, we edge, we fall, re edge,
	// re fall, ready low
	// ------------------------------------------------------------
	logic [3:0] pin_q;
	logic [3:0] cnt_q [6];
	wire tick;
	wire [5:0] restart;
	assign tick = flash_clk ^ pin_q[3];
	assign restart[0] = flash_chip_select_n ^ pin_q[2];
	assign restart[1] = flash_write_strobe_n ^ pin_q[1];
	assign restart[2] = pin_q[1] & ~flash_write_strobe_n;
	assign restart[3] = flash_read_strobe_n ^ pin_q[0];
	assign restart[4] = pin_q[0] & ~flash_read_strobe_n;
	assign restart[5] = ~flash_ready;

	// counters start saturated so reset is not taken for a recent edge
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_q <= 4'h7;
			cnt_q <= '{default: 4'hF};
		end
		else
		begin
			pin_q <= {flash_clk, flash_chip_select_n, flash_write_strobe_n,
				flash_read_strobe_n};
			for (int i = 0; i < 6; i++)
				cnt_q[i] <= restart[i] ? 4'h0 :
					cnt_q[i] + 4'(tick && cnt_q[i] != 4'hF);
		end
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	AST_EDGE_ON_TICK:
	assert property ($changed({flash_write_strobe_n, flash_read_strobe_n})
		|-> tick) else $error("strobe off clock edge");
	AST_CE_SETUP:
	assert property ($fell(flash_write_strobe_n) |-> !flash_chip_select_n
		&& cnt_q[0] >= 4'h1) else $error("select setup short");
	AST_CE_HOLD:
	assert property ($rose(flash_chip_select_n) |-> flash_write_strobe_n
		&& cnt_q[1] >= 4'h1) else $error("select hold short");
	AST_WE_CYCLE:
	assert property ($fell(flash_write_strobe_n) |-> cnt_q[2] >= 4'h3)
		else $error("write cycle short");
	AST_WE_HIGH:
	assert property ($fell(flash_write_strobe_n) |-> cnt_q[1] >= 4'h1)
		else $error("write high short");
	AST_RDY_WAIT:
	assert property ($fell(flash_read_strobe_n) |-> cnt_q[5] >= 4'h8)
		else $error("read after ready too soon");
	AST_RE_LOW:
	assert property ($rose(flash_read_strobe_n) |-> cnt_q[3] >= 4'h2)
		else $error("read low short");
	AST_RE_CYCLE:
	assert property ($fell(flash_read_strobe_n) |-> cnt_q[4] >= 4'h3)
		else $error("read cycle short");
	AST_CLK_LIMIT:
	assert property ($changed(flash_clk) |=> $stable(flash_clk))
		else $error("flash clock too fast");
	AST_LATCH_HOLD:
	assert property (($fell(cmd_latch_enable) || $fell(addr_latch_enable))
		|-> flash_write_strobe_n && cnt_q[1] >= 4'h1)
		else $error("latch enable hold short");
	AST_OE_WRITE:
	assert property (!flash_write_strobe_n |-> flash_data_oe)
		else $error("write data not driven");
	AST_OE_READ:
	assert property (!flash_read_strobe_n |-> !flash_data_oe)
		else $error("data driven during read");
endmodule // nand_strobe_chk

bind nand_strobe_timing nand_strobe_chk nand_strobe_chk_i (.clock,
	.reset_n, .flash_clk, .flash_chip_select_n, .flash_write_strobe_n,
	.flash_read_strobe_n, .flash_ready, .cmd_latch_enable,
	.addr_latch_enable, .flash_data_oe);

// ### testbench/nand_flash_model.sv
module nand_flash_model #(
	parameter logic [7:0] BASE = 8'h3C,
	parameter logic [7:0] BUSY_CMD = 8'h30
)(
	input wire logic clock,
	input wire logic cmd_latch_enable,
	input wire logic addr_latch_enable,
	input wire logic flash_chip_select_n,
	input wire logic flash_write_strobe_n,
	input wire logic flash_read_strobe_n,
	input wire logic [7:0] flash_data_out,
	output logic [7:0] flash_data_in,
	output logic flash_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// latch, busy and read data
	// ------------------------------------------------------------
	logic [1:0] lat_kind = 2'b11;
	logic [7:0] lat_byte = 8'h00;
	logic [7:0] rd_idx = 8'h00;
	int busy_cyc = 0;
	initial
	begin
		flash_data_in = 8'h00;
		flash_ready = 1'b1;
	end
	always @(posedge flash_write_strobe_n)
	begin
		if (flash_chip_select_n === 1'b0)
		begin
			lat_kind = {cmd_latch_enable, addr_latch_enable};
			lat_byte = flash_data_out;
			if (cmd_latch_enable)
				rd_idx = 8'h00;
			if (cmd_latch_enable && flash_data_out == BUSY_CMD)
				busy_cyc = 40;
		end
	end
	always @(posedge clock)
	begin
		if (busy_cyc > 0)
			busy_cyc--;
		flash_ready <= (busy_cyc == 0);
	end
	// select is looked at after the delay: it may fall with the strobe
	always @(negedge flash_read_strobe_n)
	begin
		#12;
		if (flash_chip_select_n === 1'b0)
			flash_data_in = BASE + rd_idx;
	end
	// no hold: a released bus shows the inverse, never the old byte
	always @(posedge flash_read_strobe_n)
	begin
		if (flash_chip_select_n === 1'b0)
		begin
			flash_data_in = ~flash_data_in;
			rd_idx = rd_idx + 8'h01;
		end
	end
endmodule // nand_flash_model

// ### testbench/nand_strobe_timing_test.sv
module nand_strobe_timing_test
	import nand_strobe_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] RD_BASE = 8'h3C;
	logic clock = 0, reset_n = 0, div_load = 0, op_valid = 0, rd_ready = 0;
	logic [DIV_W-1:0] flash_clk_divider = 5'h10;
	op_e op_kind = OP_CMD;
	logic [7:0] op_data = 8'h00;
	wire op_ready, rd_valid, busy, flash_clk, cmd_latch_enable;
	wire addr_latch_enable, flash_chip_select_n, flash_write_strobe_n;
	wire flash_read_strobe_n, flash_data_oe, flash_ready;
	wire [7:0] rd_data, flash_data_out, flash_data_in, from_flash;
	int error_cnt = 0, comparisons = 0;
	assign flash_data_in = flash_data_oe ? flash_data_out : from_flash;
	always #4 clock = ~clock;

	nand_strobe_timing nand_strobe_timing_i (.clock, .reset_n, .div_load,
		.flash_clk_divider, .op_valid, .op_ready, .op_kind, .op_data,
		.rd_valid, .rd_ready, .rd_data, .busy, .flash_clk,
		.cmd_latch_enable, .addr_latch_enable, .flash_chip_select_n,
		.flash_write_strobe_n, .flash_read_strobe_n, .flash_data_out,
		.flash_data_oe, .flash_data_in, .flash_ready);
	nand_flash_model #(.BASE(RD_BASE)) nand_flash_model_i (.clock,
		.cmd_latch_enable, .addr_latch_enable, .flash_chip_select_n,
		.flash_write_strobe_n, .flash_read_strobe_n, .flash_data_out,
		.flash_data_in(from_flash), .flash_ready);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic fail(input string m);
		error_cnt++;
		$display("unexpected %0t %s", $time, m);
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic issue(input op_e k, input logic [7:0] d);
		@(posedge clock);
		op_kind <= k;
		op_data <= d;
		op_valid <= 1'b1;
		do
			@(posedge clock);
		while (op_ready !== 1'b1);
		op_valid <= 1'b0;
	endtask
	task automatic wait_idle();
		repeat (2) @(posedge clock);
		while (busy !== 1'b0)
			@(posedge clock);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// zero keeps the divider; a change may stretch one phase, so wait
	task automatic t_clock(input logic [DIV_W-1:0] d, input int h);
		int n;
		logic f;
		@(posedge clock);
		flash_clk_divider <= d;
		div_load <= (d != 5'h00);
		@(posedge clock);
		div_load <= 1'b0;
		repeat (12) @(posedge clock);
		f = flash_clk;
		while (flash_clk === f)
			@(posedge clock);
		f = flash_clk;
		n = 0;
		while (flash_clk === f)
		begin
			@(posedge clock);
			n++;
		end
		comparisons++;
		if (n != h)
			fail("flash clock half period");
	endtask
	task automatic t_write();
		op_e k [3] = '{OP_CMD, OP_ADDR, OP_WRITE};
		logic [7:0] d [3] = '{8'h80, 8'h05, 8'hA5};
		for (int i = 0; i < 3; i++)
		begin
			issue(k[i], d[i]);
			wait_idle();
			comparisons++;
			if (nand_flash_model_i.lat_byte !== d[i] ||
				nand_flash_model_i.lat_kind !== {k[i] == OP_CMD,
				k[i] == OP_ADDR})
				fail("latched byte or kind");
		end
	endtask
	// two reads fill the buffer while the consumer stalls
	task automatic t_read();
		int n = 0;
		issue(OP_CMD, 8'h30);
		wait_idle();
		issue(OP_READ, 8'h00);
		issue(OP_READ, 8'h00);
		wait_idle();
		op_kind <= OP_READ;
		op_valid <= 1'b1;
		repeat (40)
		begin
			@(posedge clock);
			if (op_ready === 1'b1)
				n++;
		end
		op_valid <= 1'b0;
		comparisons++;
		if (n != 0)
			fail("read taken while full");
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clock);
			comparisons++;
			if (rd_valid !== 1'b1 || rd_data !== RD_BASE + 8'(i))
				fail("read byte");
			rd_ready <= 1'b1;
			@(posedge clock);
			rd_ready <= 1'b0;
		end
		@(posedge clock);
		comparisons++;
		if (rd_valid !== 1'b0)
			fail("buffer not empty");
	endtask

	initial
	begin
		repeat (30000) @(posedge clock);
		fail("watchdog");
		complete_run();
	end
	// cycles per half period at 125 MHz follow from the divide ratio
	initial
	begin
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		t_clock(5'h00, 4);
		t_write();
		t_read();
		t_clock(DIV_SLOW, 3);
		t_clock(5'h01, 2);
		t_clock(DIV_FAST, 2);
		t_write();
		t_read();
		complete_run();
	end
endmodule // nand_strobe_timing_test
